// ===== logic/fpr_round_except.sv
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
// Behaviour
// - bracket exact value, pick by mode
// - mode 00 nearest, ties to even
// - mode 01 round toward minus infinity
// - mode 10 round toward plus infinity
// - mode 11 truncate toward zero
// - rounding error below one lsb
// - inexact result sets precision flag
// - no rounding for compare, exact, nan
// - scalar mode in control bits 10-11
// - vector mode in register bits 13-14
// - each mode field steers own unit
// - vector truncating conversions round toward zero
// - six exception classes detected
// - invalid, divzero, denormal checked before arithmetic
// - overflow, underflow, inexact checked after rounding
// - masked exception: flag, default result, continue
// - unmasked exception: flag and trap
// - flags sticky until software clears
// - scalar flags status 0-5, masks control 0-5
// - vector flags bits 0-5, masks 7-12
// - each unit uses own flags, masks
// - several masked exceptions per operation
// - masked overflow: infinity or largest finite
// - masked divzero: infinity, sign xor
module fpr_round_except (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // avalon-mm register slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // operation in
   input wire logic req_valid_i,
   input wire fpr_pkg::fpr_req_s req_i,
   // result out
   output logic resp_valid_o,
   output fpr_pkg::fpr_resp_s resp_o
);
   localparam int EW = fpr_pkg::EXP_W;
   localparam int SW = fpr_pkg::SIG_W;

   logic [5:0] sc_mask_q;
   logic [1:0] sc_rc_q;
   logic [5:0] sc_flag_q;
   logic [5:0] vc_mask_q;
   logic [1:0] vc_rc_q;
   logic [5:0] vc_flag_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic resp_valid_q;
   fpr_pkg::fpr_resp_s resp_q;

   logic [31:0] be_bits;
   logic wr_take;
   logic sel_sc_ctrl;
   logic sel_sc_stat;
   logic sel_vc;
   logic [31:0] sc_ctrl_word;
   logic [31:0] sc_stat_word;
   logic [31:0] vc_word;

   // per-operation combinational results
   logic [1:0] mode;
   logic [5:0] mask;
   logic [5:0] pre;
   logic [5:0] post;
   logic lsb_bit;
   logic guard_bit;
   logic sticky_bit;
   logic inexact;
   logic inc;
   logic [SW:0] sig_sum;
   logic signed [EW+1:0] exp_r;
   logic [SW-1:0] sig_r;
   logic ovf;
   logic tiny;
   logic inf_on_ovf;
   fpr_pkg::fpr_resp_s resp_d;

   // byte enables widened to a bit mask
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         be_bits[i*8 +: 8] = {8{avs_byteenable_i[i]}};
      end
   end

   // register decode; an access lands at the edge where waitrequest is low
   assign wr_take = avs_write_i && !wait_q;
   always_comb begin
      sel_sc_ctrl = 1'b0;
      sel_sc_stat = 1'b0;
      sel_vc = 1'b0;
      if (avs_address_i == fpr_pkg::OFS_SCALAR_CTRL) begin
         sel_sc_ctrl = 1'b1;
      end else if (avs_address_i == fpr_pkg::OFS_SCALAR_STAT) begin
         sel_sc_stat = 1'b1;
      end else if (avs_address_i == fpr_pkg::OFS_VECTOR_CS) begin
         sel_vc = 1'b1;
      end
   end

   // register images as software sees them
   always_comb begin
      sc_ctrl_word = 32'h0000_0000;
      sc_ctrl_word[fpr_pkg::SC_MASK_LSB +: 6] = sc_mask_q;
      sc_ctrl_word[fpr_pkg::SC_RC_LSB +: 2] = sc_rc_q;
      sc_stat_word = 32'h0000_0000;
      sc_stat_word[fpr_pkg::SS_FLAG_LSB +: 6] = sc_flag_q;
      vc_word = 32'h0000_0000;
      vc_word[fpr_pkg::VC_FLAG_LSB +: 6] = vc_flag_q;
      vc_word[fpr_pkg::VC_MASK_LSB +: 6] = vc_mask_q;
      vc_word[fpr_pkg::VC_RC_LSB +: 2] = vc_rc_q;
   end

   // one wait cycle, then a single-cycle answer
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wait_q <= 1'b1;
      end else if ((avs_read_i || avs_write_i) && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   // read data loaded during the wait cycle; unmapped reads give zero
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read_i && wait_q) begin
         if (sel_sc_ctrl) begin
            rdata_q <= sc_ctrl_word;
         end else if (sel_sc_stat) begin
            rdata_q <= sc_stat_word;
         end else if (sel_vc) begin
            rdata_q <= vc_word;
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;

   // scalar control word: masks and rounding mode
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sc_mask_q <= fpr_pkg::MASK_RESET;
         sc_rc_q <= fpr_pkg::RC_RESET;
      end else if (wr_take && sel_sc_ctrl) begin
         if (avs_byteenable_i[0]) begin
            sc_mask_q <= avs_writedata_i[fpr_pkg::SC_MASK_LSB +: 6];
         end
         if (avs_byteenable_i[1]) begin
            sc_rc_q <= avs_writedata_i[fpr_pkg::SC_RC_LSB +: 2];
         end
      end
   end

   // vector register: masks and rounding mode
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         vc_mask_q <= fpr_pkg::MASK_RESET;
         vc_rc_q <= fpr_pkg::RC_RESET;
      end else if (wr_take && sel_vc) begin
         vc_mask_q <= (vc_mask_q & ~be_bits[fpr_pkg::VC_MASK_LSB +: 6]) |
            (avs_writedata_i[fpr_pkg::VC_MASK_LSB +: 6] &
             be_bits[fpr_pkg::VC_MASK_LSB +: 6]);
         vc_rc_q <= (vc_rc_q & ~be_bits[fpr_pkg::VC_RC_LSB +: 2]) |
            (avs_writedata_i[fpr_pkg::VC_RC_LSB +: 2] &
             be_bits[fpr_pkg::VC_RC_LSB +: 2]);
      end
   end

   // scalar flags: writing 0 clears, raised bits win over a clear
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sc_flag_q <= fpr_pkg::FLAG_RESET;
      end else begin
         sc_flag_q <= ((wr_take && sel_sc_stat) ?
            (sc_flag_q & (avs_writedata_i[5:0] | ~be_bits[5:0])) :
            sc_flag_q) |
            ((req_valid_i && !req_i.unit_vector) ? resp_d.raised :
             6'h00);
      end
   end

   // vector flags: same policy, own register
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         vc_flag_q <= fpr_pkg::FLAG_RESET;
      end else begin
         vc_flag_q <= ((wr_take && sel_vc) ?
            (vc_flag_q & (avs_writedata_i[5:0] | ~be_bits[5:0])) :
            vc_flag_q) |
            ((req_valid_i && req_i.unit_vector) ? resp_d.raised :
             6'h00);
      end
   end

   // mode and mask come from the unit that runs the operation
   always_comb begin
      mode = req_i.unit_vector ? vc_rc_q : sc_rc_q;
      mask = req_i.unit_vector ? vc_mask_q : sc_mask_q;
      if (req_i.unit_vector && req_i.kind == fpr_pkg::FPR_TRUNC_CONV) begin
         mode = fpr_pkg::RC_ZERO;
      end
   end

   // operand checks ahead of any arithmetic
   always_comb begin
      pre = 6'h00;
      pre[fpr_pkg::EX_INVALID] = req_i.pre_invalid;
      pre[fpr_pkg::EX_DIVZERO] = req_i.pre_divzero;
      pre[fpr_pkg::EX_DENORMAL] = req_i.pre_denormal;
   end

   // rounding: truncated value and truncated plus one lsb bracket it
   always_comb begin
      lsb_bit = req_i.sig[2];
      guard_bit = req_i.sig[1];
      sticky_bit = req_i.sig[0];
      inexact = guard_bit | sticky_bit;
      case (mode)
         fpr_pkg::RC_NEAREST: inc = guard_bit & (sticky_bit | lsb_bit);
         fpr_pkg::RC_DOWN: inc = inexact & req_i.sign;
         fpr_pkg::RC_UP: inc = inexact & !req_i.sign;
         default: inc = 1'b0;
      endcase
      // one increment at most keeps the error under one lsb
      sig_sum = {1'b0, req_i.sig[SW+1:2]} + {{SW{1'b0}}, inc};
      if (sig_sum[SW]) begin
         sig_r = sig_sum[SW:1];
         exp_r = req_i.exp + {{(EW+1){1'b0}}, 1'b1};
      end else begin
         sig_r = sig_sum[SW-1:0];
         exp_r = req_i.exp;
      end
      ovf = exp_r >= $signed({2'b00, fpr_pkg::EXP_MAX});
      tiny = (exp_r < $signed({{(EW+1){1'b0}}, 1'b1})) && (|sig_r);
      inf_on_ovf = (mode == fpr_pkg::RC_NEAREST) ||
         (mode == fpr_pkg::RC_DOWN && req_i.sign) ||
         (mode == fpr_pkg::RC_UP && !req_i.sign);
   end

   // result selection and exception response
   always_comb begin
      post = 6'h00;
      resp_d = '0;
      resp_d.sign = req_i.sign;
      if (|(pre & ~mask)) begin
         // unmasked operand exception: stop before arithmetic
         resp_d.raised = pre;
      end else if (req_i.pre_invalid) begin
         // masked invalid: quiet indefinite value
         resp_d.sign = 1'b1;
         resp_d.exp = fpr_pkg::EXP_MAX;
         resp_d.frac = {1'b1, {(SW-2){1'b0}}};
         resp_d.raised = pre;
      end else if (req_i.pre_divzero) begin
         resp_d.sign = req_i.sign ^ req_i.sign_b;
         resp_d.exp = fpr_pkg::EXP_MAX;
         resp_d.raised = pre;
      end else if (req_i.kind == fpr_pkg::FPR_COMPARE ||
                   req_i.kind == fpr_pkg::FPR_EXACT ||
                   req_i.kind == fpr_pkg::FPR_NAN) begin
         // passed through with no rounding and no precision flag
         resp_d.exp = (req_i.kind == fpr_pkg::FPR_NAN) ? fpr_pkg::EXP_MAX :
            req_i.exp[EW-1:0];
         resp_d.frac = req_i.sig[SW:2];
         resp_d.raised = pre;
      end else begin
         // masked denormal falls through to here and is kept in pre
         post[fpr_pkg::EX_PRECISION] = inexact;
         post[fpr_pkg::EX_OVERFLOW] = ovf;
         post[fpr_pkg::EX_UNDERFLOW] = tiny &&
            (inexact || !mask[fpr_pkg::EX_UNDERFLOW]);
         if (ovf) begin
            post[fpr_pkg::EX_PRECISION] = 1'b1;
            resp_d.exp = inf_on_ovf ? fpr_pkg::EXP_MAX :
               fpr_pkg::EXP_MAX - {{(EW-1){1'b0}}, 1'b1};
            resp_d.frac = inf_on_ovf ? '0 : {(SW-1){1'b1}};
         end else if (tiny) begin
            resp_d.exp = '0;
            resp_d.frac = sig_r[SW-2:0];
         end else begin
            resp_d.exp = exp_r[EW-1:0];
            resp_d.frac = sig_r[SW-2:0];
         end
         resp_d.raised = pre | post;
      end
      resp_d.trap = |(resp_d.raised & ~mask);
   end

   // result register, one cycle after the operation is taken
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         resp_valid_q <= 1'b0;
         resp_q <= '0;
      end else begin
         resp_valid_q <= req_valid_i;
         if (req_valid_i) begin
            resp_q <= resp_d;
         end
      end
   end

   assign resp_valid_o = resp_valid_q;
   assign resp_o = resp_q;
endmodule

// ===== logic/fpr_pkg.sv
package fpr_pkg;
   // destination format: exponent width and significand width (hidden bit in)
   localparam int EXP_W = 8;
   localparam int SIG_W = 24;
   localparam logic [EXP_W-1:0] EXP_MAX = {EXP_W{1'b1}};

   // register byte offsets
   localparam logic [3:0] OFS_SCALAR_CTRL = 4'h0;
   localparam logic [3:0] OFS_SCALAR_STAT = 4'h4;
   localparam logic [3:0] OFS_VECTOR_CS = 4'h8;

   // field positions
   localparam int SC_MASK_LSB = 0;
   localparam int SC_RC_LSB = 10;
   localparam int SS_FLAG_LSB = 0;
   localparam int VC_FLAG_LSB = 0;
   localparam int VC_MASK_LSB = 7;
   localparam int VC_RC_LSB = 13;

   // exception bit order inside every six-bit flag or mask group
   localparam int EX_INVALID = 0;
   localparam int EX_DENORMAL = 1;
   localparam int EX_DIVZERO = 2;
   localparam int EX_OVERFLOW = 3;
   localparam int EX_UNDERFLOW = 4;
   localparam int EX_PRECISION = 5;

   // reset values
   localparam logic [5:0] MASK_RESET = 6'h3F;
   localparam logic [5:0] FLAG_RESET = 6'h00;
   localparam logic [1:0] RC_RESET = 2'h0;

   // rounding_control encodings
   localparam logic [1:0] RC_NEAREST = 2'h0;
   localparam logic [1:0] RC_DOWN = 2'h1;
   localparam logic [1:0] RC_UP = 2'h2;
   localparam logic [1:0] RC_ZERO = 2'h3;

   typedef enum logic [2:0] {
      FPR_ARITH,
      FPR_EXACT,
      FPR_COMPARE,
      FPR_NAN,
      FPR_TRUNC_CONV
   } fpr_kind_e;

   // one operation handed in for rounding and exception checking
   typedef struct packed {
      logic unit_vector;
      fpr_kind_e kind;
      logic sign;
      logic sign_b;
      logic signed [EXP_W+1:0] exp;
      logic [SIG_W+1:0] sig;
      logic pre_invalid;
      logic pre_divzero;
      logic pre_denormal;
   } fpr_req_s;

   // delivered result
   typedef struct packed {
      logic sign;
      logic [EXP_W-1:0] exp;
      logic [SIG_W-2:0] frac;
      logic [5:0] raised;
      logic trap;
   } fpr_resp_s;
endpackage

// ===== dv/fpr_round_except_sva.sv
`timescale 1ns/10ps
module fpr_round_except_sva (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // register bus handshake
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   // operation in and result out
   input wire logic req_valid_i,
   input wire fpr_pkg::fpr_req_s req_i,
   input wire logic resp_valid_o,
   input wire fpr_pkg::fpr_resp_s resp_o
);
   fpr_pkg::fpr_req_s req_q;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   // last operation, kept to compare against its result
   always_ff @(posedge clock_i) begin
      req_q <= req_i;
   end

   // a bus request seen while the slave still waits
   sequence bus_req_seq;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence

   // an operation free of operand-check exceptions
   sequence clean_seq;
      req_valid_i && !req_i.pre_invalid && !req_i.pre_divzero
         && !req_i.pre_denormal;
   endsequence

   bus_answer_a: assert property (bus_req_seq |=> !avs_waitrequest_o ##1
      avs_waitrequest_o) else $error("bus answer not one cycle wide");
   resp_pulse_a: assert property (req_valid_i |=> resp_valid_o)
      else $error("result valid missing after request");
   prec_flag_a: assert property (
      clean_seq ##0 (req_i.kind == fpr_pkg::FPR_ARITH && |req_i.sig[1:0])
      |=> resp_o.raised[fpr_pkg::EX_PRECISION])
      else $error("inexact result without precision flag");
   rnd_error_a: assert property (
      clean_seq ##0 (req_i.kind == fpr_pkg::FPR_ARITH
      && req_i.exp inside {[10'sd1:10'sd253]})
      |=> 23'(resp_o.frac - req_q.sig[fpr_pkg::SIG_W:2]) <= 23'h1)
      else $error("rounding moved result by more than one lsb");
   exact_quiet_a: assert property (
      req_valid_i && req_i.kind inside {fpr_pkg::FPR_EXACT,
      fpr_pkg::FPR_COMPARE, fpr_pkg::FPR_NAN}
      |=> !resp_o.raised[fpr_pkg::EX_PRECISION])
      else $error("precision flag on unrounded operation");
   nan_pass_a: assert property (
      clean_seq ##0 (req_i.kind == fpr_pkg::FPR_NAN)
      |=> resp_o.exp == fpr_pkg::EXP_MAX
      && resp_o.frac == req_q.sig[fpr_pkg::SIG_W:2])
      else $error("nan result was altered");
   divzero_flag_a: assert property (
      req_valid_i && req_i.pre_divzero
      |=> resp_o.raised[fpr_pkg::EX_DIVZERO])
      else $error("divide by zero not raised");
   divzero_inf_a: assert property (
      req_valid_i && req_i.pre_divzero && !req_i.pre_invalid
      |=> resp_o.trap || (resp_o.sign == (req_q.sign ^ req_q.sign_b)
      && resp_o.exp == fpr_pkg::EXP_MAX && resp_o.frac == 23'h0))
      else $error("masked divide by zero result not signed infinity");
endmodule

bind fpr_round_except fpr_round_except_sva chk (
   .clock_i, .rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
   .req_valid_i, .req_i, .resp_valid_o, .resp_o
);

// ===== dv/fpr_round_except_tb_top.sv
`timescale 1ns/10ps
module fpr_round_except_tb_top;
   localparam logic [25:0] ODD = {24'hC00001, 2'b10};
   localparam logic [25:0] ONE = {24'h800000, 2'b00};
   localparam fpr_pkg::fpr_kind_e AR = fpr_pkg::FPR_ARITH;
   localparam fpr_pkg::fpr_kind_e TC = fpr_pkg::FPR_TRUNC_CONV;
   logic clock_i;
   logic rst_i;
   logic [3:0] avs_address_i;
   logic avs_read_i;
   logic avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0] avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic req_valid_i;
   fpr_pkg::fpr_req_s req_i;
   logic resp_valid_o;
   fpr_pkg::fpr_resp_s resp_o;
   logic [31:0] rdat;
   int error_cnt;
   int checks_done;

   // design under test, byte lanes driven by the bench
   fpr_round_except dut (
      .clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .req_valid_i, .req_i, .resp_valid_o, .resp_o
   );

   // 125 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   // counts, verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // compare one value
   task automatic check(input string nm, input logic [63:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one bus access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      @(posedge clock_i);
      while (avs_waitrequest_o !== 1'b0) begin
         n++;
         if (n > 20) begin
            error_cnt++;
            close_out();
         end
         @(posedge clock_i);
      end
      rdat = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clock_i);
   endtask

   // read a register and compare
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check($sformatf("reg_%h", a), {32'h0, rdat}, {32'h0, e});
   endtask

   // build an operation
   function automatic fpr_pkg::fpr_req_s rq(logic uv, fpr_pkg::fpr_kind_e k,
      logic s, logic sb, logic [9:0] ex, logic [25:0] sg, logic [2:0] pre);
      return '{uv, k, s, sb, ex, sg, pre[2], pre[1], pre[0]};
   endfunction

   // one operation and its result one cycle later
   task automatic op(input fpr_pkg::fpr_req_s r, input fpr_pkg::fpr_resp_s e);
      req_i <= r;
      req_valid_i <= 1'b1;
      @(posedge clock_i);
      req_valid_i <= 1'b0;
      @(posedge clock_i);
      check("resp_valid", {63'h0, resp_valid_o}, 64'h1);
      check("resp", {25'h0, resp_o}, {25'h0, e});
   endtask

   // main sequence
   initial begin
      logic [1:0] m;
      logic s;
      logic inc;
      rst_i = 1'b1;
      avs_address_i = 4'h0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'hF;
      req_valid_i = 1'b0;
      req_i = '0;
      error_cnt = 0;
      checks_done = 0;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(4'h0, 32'h3F);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h1F80);
      rd(4'hC, 32'h0);
      $display("test reset values done");
      // every mode on a tie with odd lsb, both signs
      for (int i = 0; i < 8; i++) begin
         m = i[2:1];
         s = i[0];
         inc = m == 2'h0 || (m == 2'h1 && s) || (m == 2'h2 && !s);
         bus(1'b1, 4'h0, {20'h0, m, 10'h03F});
         op(rq(1'b0, AR, s, 1'b0, 10'd100, ODD, 3'h0), '{s, 8'd100,
            23'h400001 + {22'h0, inc}, 6'h20, 1'b0});
      end
      $display("test rounding modes done");
      op(rq(1'b1, AR, 1'b0, 1'b0, 10'd100, ODD, 3'h0),
         '{1'b0, 8'd100, 23'h400002, 6'h20, 1'b0});
      op(rq(1'b1, TC, 1'b0, 1'b0, 10'd100, ODD, 3'h0),
         '{1'b0, 8'd100, 23'h400001, 6'h20, 1'b0});
      bus(1'b1, 4'h0, 32'h3F);
      op(rq(1'b0, TC, 1'b0, 1'b0, 10'd100, ODD, 3'h0),
         '{1'b0, 8'd100, 23'h400002, 6'h20, 1'b0});
      op(rq(1'b0, AR, 1'b0, 1'b0, 10'd100, {24'hC00002, 2'b10}, 3'h0),
         '{1'b0, 8'd100, 23'h400002, 6'h20, 1'b0});
      rd(4'h4, 32'h20);
      rd(4'h8, 32'h1FA0);
      op(rq(1'b1, fpr_pkg::FPR_COMPARE, 1'b0, 1'b0, 10'd100, ODD, 3'h0),
         '{1'b0, 8'd100, 23'h400001, 6'h00, 1'b0});
      op(rq(1'b1, fpr_pkg::FPR_NAN, 1'b0, 1'b0, 10'd100, ODD, 3'h0),
         '{1'b0, 8'hFF, 23'h400001, 6'h00, 1'b0});
      $display("test unit separation done");
      op(rq(1'b0, AR, 1'b0, 1'b0, 10'd100, ONE, 3'h4),
         '{1'b1, 8'hFF, 23'h400000, 6'h01, 1'b0});
      op(rq(1'b0, AR, 1'b0, 1'b1, 10'd100, ONE, 3'h2),
         '{1'b1, 8'hFF, 23'h0, 6'h04, 1'b0});
      bus(1'b1, 4'h0, 32'h3B);
      op(rq(1'b0, AR, 1'b0, 1'b1, 10'd100, ONE, 3'h2),
         '{1'b0, 8'h00, 23'h0, 6'h04, 1'b1});
      bus(1'b1, 4'h0, 32'h3F);
      op(rq(1'b0, AR, 1'b0, 1'b0, 10'd255, ONE, 3'h0),
         '{1'b0, 8'hFF, 23'h0, 6'h28, 1'b0});
      // only the mode byte lane is written; masks must stay set
      avs_byteenable_i <= 4'h2;
      bus(1'b1, 4'h0, 32'hC00);
      avs_byteenable_i <= 4'hF;
      rd(4'h0, 32'hC3F);
      op(rq(1'b0, AR, 1'b0, 1'b0, 10'd255, ONE, 3'h0),
         '{1'b0, 8'hFE, 23'h7FFFFF, 6'h28, 1'b0});
      bus(1'b1, 4'h0, 32'h3F);
      op(rq(1'b0, AR, 1'b0, 1'b0, 10'd0, {24'h800000, 2'b01}, 3'h1),
         '{1'b0, 8'h00, 23'h0, 6'h32, 1'b0});
      $display("test exceptions done");
      op(rq(1'b0, fpr_pkg::FPR_EXACT, 1'b0, 1'b0, 10'd100, ONE, 3'h0),
         '{1'b0, 8'd100, 23'h0, 6'h00, 1'b0});
      rd(4'h4, 32'h3F);
      bus(1'b1, 4'h4, 32'h0);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h1FA0);
      $display("test sticky flags done");
      close_out();
   end
endmodule
